// file: src/bcce_pkg.sv
// Constants, opcode patterns and state type of the branch/call/compare
// execution unit. Assumes an 8-bit core with 16-bit instruction words.
package bcce_pkg;

    // Opcode patterns
    localparam logic [7:0] OPC_BZ = 8'hE0;
    localparam logic [6:0] OPC_CALL1 = 7'h76;
    localparam logic [3:0] OPC_WORD2 = 4'hF;
    localparam logic [6:0] OPC_CLEAR_FILE_REG = 7'h35;
    localparam logic [5:0] OPC_INVERT_FILE_REG = 6'h07;
    localparam logic [5:0] OPC_DECREMENT_FILE_OP = 6'h01;
    localparam logic [6:0] OPC_SKEQ = 7'h31;
    localparam logic [6:0] OPC_SKGT = 7'h32;
    localparam logic [6:0] OPC_SKLT = 7'h30;
    localparam logic [15:0] OPC_CLEAR_WATCHDOG_OP = 16'h0004;
    localparam logic [15:0] OPC_DAW = 16'h0007;
    localparam logic [15:0] OPC_NOP = 16'h0000;
    localparam logic [7:0] OPC_GOTO1 = 8'hEF;
    localparam logic [7:0] OPC_LFSR1 = 8'hEE;
    localparam logic [3:0] OPC_MOVFF1 = 4'hC;

    // Field positions in the first word
    localparam int BIT_ACCESS = 8;
    localparam int BIT_DEST = 9;
    localparam int BIT_SHADOW = 8;

    // Flag positions in the flags register
    localparam int FLG_C = 0;
    localparam int FLG_DC = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_OV = 3;
    localparam int FLG_N = 4;

    // Access bank split and arithmetic constants
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
    localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
    localparam logic [3:0] BCD_LIMIT = 4'h9;
    localparam logic [3:0] BCD_FIX = 4'h6;
    localparam logic [20:0] PC_STEP1 = 21'h000002;
    localparam logic [20:0] PC_STEP2 = 21'h000004;

    // Reset values and skip discard count
    localparam logic [7:0] RST_ACC = 8'h00;
    localparam logic [4:0] RST_FLAGS = 5'h00;
    localparam logic RST_STATUS_BITS = 1'b1;
    localparam logic [1:0] DISCARD_ONE = 2'h1;

    typedef enum logic [3:0] {
        ST_FETCH = 4'b0001,
        ST_EXEC = 4'b0010,
        ST_CALL_WAIT = 4'b0100,
        ST_CALL_EXEC = 4'b1000
    } bcce_state_type;

endpackage

// file: src/bcce_exec.sv
// Execution unit for branch-on-zero, call, clear/invert/decrement of a
// file register, watchdog clear, compare-and-skip and decimal adjust.
// Assumes the fetch stage hands one word per accept with its address,
// and data memory reads combinationally from the registered address.
`timescale 1ns/10ps

module bcce_exec
    import bcce_pkg::*;
#(
    parameter int PC_W = 21,
    parameter int ADDR_W = 12
)
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Instruction words from fetch
    input wire logic instr_valid_i,
    input wire logic [15:0] instr_i,
    input wire logic [PC_W-1:0] instr_pc_i,
    output logic instr_ready_o,
    // Data memory
    output logic [ADDR_W-1:0] mem_addr_o,
    input wire logic [7:0] mem_rdata_i,
    output logic mem_we_o,
    output logic [7:0] mem_wdata_o,
    // Bank select from the core
    input wire logic [3:0] bank_select_reg_i,
    // Program counter and return stack
    output logic pc_load_o,
    output logic [PC_W-1:0] pc_target_o,
    output logic stack_push_o,
    output logic [PC_W-1:0] stack_top_entry_o,
    // Working state
    output logic [7:0] acc_o,
    output logic [4:0] flags_o,
    output logic [7:0] accumulator_shadow_o,
    output logic [4:0] flags_shadow_o,
    output logic [3:0] bank_select_shadow_o,
    // Watchdog
    output logic watchdog_counter_clr_o,
    output logic watchdog_expiry_flag_o,
    output logic sleep_entered_flag_o
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Words that are followed by a second operand word
    function automatic logic is_two_word(input logic [15:0] w);
        is_two_word = (w[15:12] == OPC_MOVFF1) ||
            (w[15:9] == OPC_CALL1) ||
            (w[15:8] == OPC_GOTO1) ||
            (w[15:8] == OPC_LFSR1);
    endfunction

    // Access bank splits at a fixed offset; bank select is ignored there
    function automatic logic [ADDR_W-1:0] file_addr(
        input logic [7:0] f,
        input logic a,
        input logic [3:0] bank_select_reg
    );
        logic [3:0] bank;
        bank = (f < ACCESS_SPLIT) ? ACCESS_LO_BANK : ACCESS_HI_BANK;
        if (a)
        begin
            bank = bank_select_reg;
        end
        file_addr = ADDR_W'({bank, f});
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    bcce_state_type state_r;
    bcce_state_type state_nxt;
    logic [1:0] discard_r;
    logic [15:0] op_r;
    logic [PC_W-1:0] pc_r;
    logic [7:0] k_lo_r;
    logic [7:0] acc_r;
    logic [4:0] flags_r;
    logic accept;
    logic is_bz;
    logic is_call1;
    logic is_clear_file_reg;
    logic is_invert_file_reg;
    logic is_decrement_file_op;
    logic is_skeq;
    logic is_skgt;
    logic is_skls;
    logic is_wdt;
    logic is_daw;
    logic [7:0] res;
    logic [4:0] flags_nxt;
    logic wr_f;
    logic wr_w;
    logic skip;
    logic [3:0] lo_fix;
    logic [3:0] hi_fix;
    logic [8:0] daw_sum;
    logic [PC_W-1:0] bz_off;

    assign accept = instr_valid_i &&
        ((state_r == ST_FETCH) || (state_r == ST_CALL_WAIT));
    assign acc_o = acc_r;
    assign flags_o = flags_r;

    ////////////////////////////////////////////////////////////////////////
    // Decode of the latched word

    always_comb
    begin
        is_bz = (op_r[15:8] == OPC_BZ);
        is_call1 = (op_r[15:9] == OPC_CALL1);
        is_clear_file_reg = (op_r[15:9] == OPC_CLEAR_FILE_REG);
        is_invert_file_reg = (op_r[15:10] == OPC_INVERT_FILE_REG);
        is_decrement_file_op = (op_r[15:10] == OPC_DECREMENT_FILE_OP);
        is_skeq = (op_r[15:9] == OPC_SKEQ);
        is_skgt = (op_r[15:9] == OPC_SKGT);
        is_skls = (op_r[15:9] == OPC_SKLT);
        is_wdt = (op_r == OPC_CLEAR_WATCHDOG_OP);
        is_daw = (op_r == OPC_DAW);
    end

    ////////////////////////////////////////////////////////////////////////
    // Data path

    always_comb
    begin
        res = 8'h00;
        flags_nxt = flags_r;
        wr_f = 1'b0;
        wr_w = 1'b0;
        skip = 1'b0;
        lo_fix = 4'h0;
        hi_fix = 4'h0;
        daw_sum = 9'h000;
        if (is_clear_file_reg)
        begin
            res = 8'h00;
            wr_f = 1'b1;
            flags_nxt[FLG_Z] = 1'b1;
        end
        else if (is_invert_file_reg || is_decrement_file_op)
        begin
            if (is_invert_file_reg)
            begin
                res = ~mem_rdata_i;
            end
            else
            begin
                res = mem_rdata_i - 8'h01;
                flags_nxt[FLG_C] = (mem_rdata_i != 8'h00);
                flags_nxt[FLG_DC] = (mem_rdata_i[3:0] != 4'h0);
                flags_nxt[FLG_OV] = (mem_rdata_i == 8'h80);
            end
            flags_nxt[FLG_N] = res[7];
            flags_nxt[FLG_Z] = (res == 8'h00);
            wr_f = op_r[BIT_DEST];
            wr_w = !op_r[BIT_DEST];
        end
        else if (is_skeq)
        begin
            skip = (mem_rdata_i == acc_r);
        end
        else if (is_skgt)
        begin
            skip = (mem_rdata_i > acc_r);
        end
        else if (is_skls)
        begin
            skip = (mem_rdata_i < acc_r);
        end
        else if (is_daw)
        begin
            // Both tests look at the original nibbles, as one 9-bit add
            if ((acc_r[3:0] > BCD_LIMIT) || flags_r[FLG_DC])
            begin
                lo_fix = BCD_FIX;
            end
            if ((acc_r[7:4] > BCD_LIMIT) || flags_r[FLG_C])
            begin
                hi_fix = BCD_FIX;
            end
            daw_sum = {1'b0, acc_r} + {1'b0, hi_fix, lo_fix};
            res = daw_sum[7:0];
            wr_w = 1'b1;
            flags_nxt[FLG_C] = flags_r[FLG_C] | daw_sum[8];
        end
    end

    // Offset doubled and sign extended to the PC width
    assign bz_off = PC_W'({{(PC_W-9){op_r[7]}}, op_r[7:0], 1'b0});

    ////////////////////////////////////////////////////////////////////////
    // Sequencing: one fetch phase and one execute phase per word

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_FETCH:
            begin
                if (accept)
                begin
                    state_nxt = ST_EXEC;
                end
            end
            ST_EXEC:
            begin
                state_nxt = is_call1 ? ST_CALL_WAIT : ST_FETCH;
            end
            ST_CALL_WAIT:
            begin
                if (accept)
                begin
                    state_nxt = ST_CALL_EXEC;
                end
            end
            ST_CALL_EXEC:
            begin
                state_nxt = ST_FETCH;
            end
            default:
            begin
                state_nxt = ST_FETCH;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_r <= ST_FETCH;
            instr_ready_o <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
            instr_ready_o <= (state_nxt == ST_FETCH) ||
                (state_nxt == ST_CALL_WAIT);
        end
    end

    // Discarded words run as no-operation cycles
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            discard_r <= 2'h0;
        end
        else if (state_r == ST_EXEC && (skip || (is_bz && flags_r[FLG_Z])))
        begin
            discard_r <= DISCARD_ONE;
        end
        else if (accept && state_r == ST_FETCH && discard_r != 2'h0)
        begin
            discard_r <= discard_r - 2'h1 +
                {1'b0, is_two_word(instr_i)};
        end
    end

    // Word latch and file address
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            op_r <= OPC_NOP;
            pc_r <= '0;
            k_lo_r <= 8'h00;
            mem_addr_o <= '0;
        end
        else if (accept && state_r == ST_FETCH)
        begin
            op_r <= (discard_r != 2'h0) ? OPC_NOP : instr_i;
            pc_r <= instr_pc_i;
            k_lo_r <= instr_i[7:0];
            mem_addr_o <= file_addr(instr_i[7:0], instr_i[BIT_ACCESS],
                bank_select_reg_i);
        end
    end

    // Write back to the file register after the execute phase
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            mem_we_o <= 1'b0;
            mem_wdata_o <= 8'h00;
        end
        else
        begin
            mem_we_o <= (state_r == ST_EXEC) && wr_f;
            mem_wdata_o <= res;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Program counter load and return stack push

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pc_load_o <= 1'b0;
            pc_target_o <= '0;
            stack_push_o <= 1'b0;
            stack_top_entry_o <= '0;
        end
        else
        begin
            pc_load_o <= 1'b0;
            stack_push_o <= 1'b0;
            if (state_r == ST_EXEC && is_bz && flags_r[FLG_Z])
            begin
                pc_load_o <= 1'b1;
                pc_target_o <= pc_r + PC_STEP1 + bz_off;
            end
            else if (accept && state_r == ST_CALL_WAIT)
            begin
                // Second word's prefix is trusted; fetch only pairs them
                pc_load_o <= 1'b1;
                pc_target_o <=
                    PC_W'({instr_i[11:0], k_lo_r, 1'b0});
                stack_push_o <= 1'b1;
                stack_top_entry_o <= pc_r + PC_STEP2;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Accumulator and flags

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            acc_r <= RST_ACC;
            flags_r <= RST_FLAGS;
        end
        else if (state_r == ST_EXEC)
        begin
            if (wr_w)
            begin
                acc_r <= res;
            end
            flags_r <= flags_nxt;
        end
    end

    // Shadow copies, taken before anything else of the call can change them
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            accumulator_shadow_o <= RST_ACC;
            flags_shadow_o <= RST_FLAGS;
            bank_select_shadow_o <= 4'h0;
        end
        else if (state_r == ST_EXEC && is_call1 && op_r[BIT_SHADOW])
        begin
            accumulator_shadow_o <= acc_r;
            flags_shadow_o <= flags_r;
            bank_select_shadow_o <= bank_select_reg_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Watchdog clear

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            watchdog_counter_clr_o <= 1'b0;
            watchdog_expiry_flag_o <= RST_STATUS_BITS;
            sleep_entered_flag_o <= RST_STATUS_BITS;
        end
        else
        begin
            watchdog_counter_clr_o <= (state_r == ST_EXEC) &&
                is_wdt;
            if (state_r == ST_EXEC && is_wdt)
            begin
                watchdog_expiry_flag_o <= 1'b1;
                sleep_entered_flag_o <= 1'b1;
            end
        end
    end

endmodule // bcce_exec

// file: testbench/bcce_exec_chk.sv
// Checker for the execution unit, watching its ports only.
// Assumes fetch hands words in program order, two bytes apart.
`timescale 1ns/10ps
module bcce_exec_chk
    import bcce_pkg::*;
#(
    parameter int PC_W = 21,
    parameter int ADDR_W = 12
)
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Watched ports
    input wire logic instr_valid_i,
    input wire logic [15:0] instr_i,
    input wire logic [PC_W-1:0] instr_pc_i,
    input wire logic instr_ready_o,
    input wire logic [ADDR_W-1:0] mem_addr_o,
    input wire logic [7:0] mem_rdata_i,
    input wire logic mem_we_o,
    input wire logic [7:0] mem_wdata_o,
    input wire logic [3:0] bank_select_reg_i,
    input wire logic pc_load_o,
    input wire logic [PC_W-1:0] pc_target_o,
    input wire logic stack_push_o,
    input wire logic [PC_W-1:0] stack_top_entry_o,
    input wire logic [4:0] flags_o,
    input wire logic watchdog_counter_clr_o,
    input wire logic watchdog_expiry_flag_o,
    input wire logic sleep_entered_flag_o
);
    logic [15:0] last_w_r;
    logic [15:0] prev_w_r;
    logic [PC_W-1:0] last_pc_r;
    logic [PC_W-1:0] prev_pc_r;
    logic [3:0] last_bank_r;
    wire take = instr_valid_i && instr_ready_o;

    ////////////////////////////////////////////////////////////////////////
    // Words taken so far, to judge the answer two cycles later
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            last_w_r <= 16'h0000;
            prev_w_r <= 16'h0000;
            last_pc_r <= '0;
            prev_pc_r <= '0;
            last_bank_r <= 4'h0;
        end
        else if (take)
        begin
            last_w_r <= instr_i;
            prev_w_r <= last_w_r;
            last_pc_r <= instr_pc_i;
            prev_pc_r <= last_pc_r;
            last_bank_r <= bank_select_reg_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    take_gap_a: assert property (take |=> !instr_ready_o ##1 instr_ready_o)
        else $error("ready not low for exactly one cycle");
    call_push_a: assert property (stack_push_o |-> pc_load_o
        && stack_top_entry_o == prev_pc_r + PC_STEP2)
        else $error("call return entry wrong");
    call_target_a: assert property (stack_push_o |->
        prev_w_r[15:9] == OPC_CALL1
        && pc_target_o == {last_w_r[11:0], prev_w_r[7:0], 1'b0})
        else $error("call target wrong");
    br_target_a: assert property (pc_load_o && !stack_push_o |->
        last_w_r[15:8] == OPC_BZ && pc_target_o == last_pc_r + PC_STEP1
        + {{(PC_W-9){last_w_r[7]}}, last_w_r[7:0], 1'b0})
        else $error("branch target wrong");
    br_zero_a: assert property (pc_load_o && !stack_push_o |->
        $past(flags_o[FLG_Z]))
        else $error("branch taken with zero flag clear");
    wdt_flags_a: assert property (watchdog_counter_clr_o |->
        last_w_r == OPC_CLEAR_WATCHDOG_OP && watchdog_expiry_flag_o
        && sleep_entered_flag_o)
        else $error("watchdog clear wrong");
    clr_zero_a: assert property (mem_we_o
        && last_w_r[15:9] == OPC_CLEAR_FILE_REG |-> mem_wdata_o == 8'h00
        && flags_o[FLG_Z])
        else $error("clear wrote nonzero or left zero flag");
    inv_data_a: assert property (mem_we_o
        && last_w_r[15:10] == OPC_INVERT_FILE_REG |-> mem_wdata_o == ~$past(mem_rdata_i))
        else $error("invert data wrong");
    dec_data_a: assert property (mem_we_o
        && last_w_r[15:10] == OPC_DECREMENT_FILE_OP
        |-> mem_wdata_o == $past(mem_rdata_i) - 8'h01)
        else $error("decrement data wrong");
    dest_bit_a: assert property (mem_we_o
        && last_w_r[15:13] == 3'h0 |-> last_w_r[BIT_DEST])
        else $error("register written with destination zero");
    bank_addr_a: assert property (mem_we_o |-> mem_addr_o ==
        {last_w_r[BIT_ACCESS] ? last_bank_r : {4{last_w_r[7]}},
        last_w_r[7:0]})
        else $error("write address bank wrong");
endmodule // bcce_exec_chk

bind bcce_exec bcce_exec_chk #(.PC_W(PC_W), .ADDR_W(ADDR_W)) chk_i (
    .clk_sys_i, .rst_n_i, .instr_valid_i, .instr_i, .instr_pc_i,
    .instr_ready_o, .mem_addr_o, .mem_rdata_i, .mem_we_o, .mem_wdata_o,
    .bank_select_reg_i, .pc_load_o, .pc_target_o, .stack_push_o,
    .stack_top_entry_o, .flags_o, .watchdog_counter_clr_o,
    .watchdog_expiry_flag_o, .sleep_entered_flag_o
);

// file: testbench/bcce_mem_model.sv
// Banked data memory beside the execution unit.
// Assumes reads follow the registered address in the same cycle.
`timescale 1ns/10ps
module bcce_mem_model
(
    // Clock
    input wire logic clk_sys_i,
    // Memory port
    input wire logic [11:0] mem_addr_i,
    input wire logic mem_we_i,
    input wire logic [7:0] mem_wdata_i,
    output logic [7:0] mem_rdata_o
);
    logic [7:0] cell_r [4096];
    assign mem_rdata_o = cell_r[mem_addr_i];
    // Plain always, so the bench may preload cells directly
    always @(posedge clk_sys_i)
    begin
        if (mem_we_i)
        begin
            cell_r[mem_addr_i] <= mem_wdata_i;
        end
    end
endmodule // bcce_mem_model

// file: testbench/bcce_exec_test.sv
// Self-checking bench for the execution unit.
// Assumes the memory model and the bound checker are compiled first.
`timescale 1ns/10ps
module bcce_exec_test;
    typedef struct packed {
        logic [15:0] w;
        logic [3:0] bk;
        logic [11:0] ad;
        logic [7:0] fv;
        logic [7:0] ea;
        logic [7:0] mv;
        logic [4:0] fl;
    } bcce_row_type;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic instr_valid_i = 1'b0;
    logic [15:0] instr_i = 16'h0000;
    logic [20:0] instr_pc_i = 21'h000000;
    logic [3:0] bank_select_reg_i = 4'h0;
    logic instr_ready_o, mem_we_o, pc_load_o, stack_push_o, wd_clr;
    logic tof, pdf;
    logic [11:0] mem_addr_o;
    logic [7:0] mem_rdata_i, mem_wdata_o, acc_o, accs;
    logic [4:0] flags_o, flgs;
    logic [3:0] bnks;
    logic [20:0] tgt, stack_top_entry, pc, p;
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;
    int loads = 0;
    int pushes = 0;
    int wclrs = 0;
    bcce_row_type r;
    // Rows: word, bank, address, preset, acc, cell after, flags
    bcce_row_type rows [11] = '{
        '{16'h6A10, 4'h0, 12'h010, 8'h5A, 8'h00, 8'h00, 5'h04},
        '{16'h6B10, 4'h3, 12'h310, 8'h11, 8'h00, 8'h00, 5'h04},
        '{16'h6A90, 4'h3, 12'hF90, 8'h22, 8'h00, 8'h00, 5'h04},
        '{16'h1C10, 4'h0, 12'h010, 8'h13, 8'hEC, 8'h13, 5'h10},
        '{16'h1F10, 4'h5, 12'h510, 8'hFF, 8'hEC, 8'h00, 5'h04},
        '{16'h0610, 4'h0, 12'h010, 8'h01, 8'hEC, 8'h00, 5'h07},
        '{16'h0410, 4'h0, 12'h010, 8'h80, 8'h7F, 8'h80, 5'h09},
        '{16'h0410, 4'h0, 12'h010, 8'h00, 8'hFF, 8'h00, 5'h10},
        '{16'h0007, 4'h0, 12'h010, 8'h00, 8'h65, 8'h00, 5'h11},
        '{16'h0410, 4'h0, 12'h010, 8'h13, 8'h12, 8'h13, 5'h03},
        '{16'h0007, 4'h0, 12'h010, 8'h13, 8'h78, 8'h13, 5'h03}};
    // Skip rows: bk picks a two-word follower from lead, ea the pushes
    bcce_row_type skips [9] = '{
        '{16'h6211, 4'h0, 12'h0, 8'h40, 8'h00, 8'h77, 5'h03},
        '{16'h6211, 4'h0, 12'h0, 8'h41, 8'h00, 8'h00, 5'h07},
        '{16'h6411, 4'h1, 12'h0, 8'h41, 8'h00, 8'h77, 5'h07},
        '{16'h6411, 4'h1, 12'h0, 8'h40, 8'h01, 8'h77, 5'h07},
        '{16'h6011, 4'h0, 12'h0, 8'h3F, 8'h01, 8'h77, 5'h07},
        '{16'h6011, 4'h0, 12'h0, 8'h40, 8'h01, 8'h00, 5'h07},
        '{16'h6011, 4'h2, 12'h0, 8'h3F, 8'h01, 8'h77, 5'h07},
        '{16'h6011, 4'h3, 12'h0, 8'h3F, 8'h01, 8'h77, 5'h07},
        '{16'h6011, 4'h4, 12'h0, 8'h3F, 8'h01, 8'h77, 5'h07}};
    // First words of every two-word kind, so each prefix is skipped once
    logic [15:0] lead [5] = '{16'h0000, 16'hEC12, 16'hEF12, 16'hEE12,
        16'hC012};

    bcce_exec dut (.clk_sys_i, .rst_n_i, .instr_valid_i, .instr_i,
        .instr_pc_i, .instr_ready_o, .mem_addr_o, .mem_rdata_i, .mem_we_o,
        .mem_wdata_o, .bank_select_reg_i, .pc_load_o, .pc_target_o(tgt),
        .stack_push_o, .stack_top_entry_o(stack_top_entry), .acc_o, .flags_o,
        .accumulator_shadow_o(accs), .flags_shadow_o(flgs),
        .bank_select_shadow_o(bnks), .watchdog_counter_clr_o(wd_clr),
        .watchdog_expiry_flag_o(tof), .sleep_entered_flag_o(pdf));
    bcce_mem_model mem (.clk_sys_i, .mem_addr_i(mem_addr_o),
        .mem_we_i(mem_we_o), .mem_wdata_i(mem_wdata_o),
        .mem_rdata_o(mem_rdata_i));

    ////////////////////////////////////////////////////////////////////////
    always #2 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i)
    begin
        cyc <= cyc + 1;
        loads <= loads + (pc_load_o === 1'b1);
        pushes <= pushes + (stack_push_o === 1'b1);
        wclrs <= wclrs + (wd_clr === 1'b1);
        if (cyc == 4000)
        begin
            err_total++;
            conclude();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Holds the word until an edge samples ready high; a hang is left
    // to the cycle ceiling so it is counted
    task automatic send(input logic [15:0] w);
        instr_valid_i <= 1'b1;
        instr_i <= w;
        instr_pc_i <= pc;
        pc = pc + 21'h2;
        do
        begin
            @(posedge clk_sys_i);
        end
        while (instr_ready_o !== 1'b1);
    endtask
    task automatic idle;
        instr_valid_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
        begin
            $display("Test passed");
        end
        else
        begin
            $display("Test failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        pc = 21'h000100;
        foreach (mem.cell_r[i]) mem.cell_r[i] = 8'h00;
        repeat (6) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        foreach (rows[i])
        begin
            r = rows[i];
            mem.cell_r[r.ad] = r.fv;
            bank_select_reg_i <= r.bk;
            send(r.w);
            idle();
            chk(acc_o, r.ea);
            chk(flags_o, r.fl);
            chk(mem.cell_r[r.ad], r.mv);
        end
        $display("table rows done");
        // Taken branch discards its follower, untaken one does not
        p = pc + 21'h2;
        send(16'h6A10);
        send(16'hE0FD);
        send(16'h1C10);
        idle();
        chk(loads, 1);
        chk(tgt, p - 21'h4);
        chk(acc_o, 8'h78);
        mem.cell_r[12'h010] = 8'h05;
        send(16'h0610);
        send(16'hE0FD);
        send(16'h1C10);
        idle();
        chk(loads, 1);
        chk(acc_o, 8'hFB);
        $display("branch done");
        mem.cell_r[12'h010] = 8'hBF;
        send(16'h1C10);
        foreach (skips[i])
        begin
            r = skips[i];
            mem.cell_r[12'h011] = r.fv;
            mem.cell_r[12'h020] = 8'h77;
            send(r.w);
            if (r.bk != 4'h0)
            begin
                send(lead[r.bk]);
            end
            send(16'h6A20);
            idle();
            chk(mem.cell_r[12'h020], r.mv);
            chk(flags_o, r.fl);
            chk(pushes, r.ea);
        end
        $display("skip done");
        for (int i = 0; i < 2; i++)
        begin
            bank_select_reg_i <= (i == 0) ? 4'h6 : 4'h9;
            mem.cell_r[12'h010] = 8'h00;
            if (i == 1)
            begin
                send(16'h1C10);
            end
            p = pc;
            send((i == 0) ? 16'hED34 : 16'hEC34);
            send(16'hF567);
            idle();
            chk(stack_top_entry, p + 21'h4);
            chk(tgt, 21'h0ACE68);
            chk(accs, 8'h40);
            chk(flgs, 5'h07);
            chk(bnks, 4'h6);
        end
        $display("call done");
        send(16'h0004);
        idle();
        chk(wclrs, 1);
        chk({tof, pdf}, 2'h3);
        $display("watchdog done");
        rst_n_i <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
        chk({acc_o, flags_o, accs, flgs}, 26'h0);
        chk({instr_ready_o, tof, pdf}, 3'h7);
        rst_n_i <= 1'b1;
        // First word offered at the first edge after release
        send(16'h1C10);
        idle();
        chk(acc_o, 8'hFF);
        $display("reset done");
        conclude();
    end
endmodule // bcce_exec_test
